// *** src/gls_pkg.sv ***
// constants for the gigabit status and extended access register bank
//==========================================================================
// Function
// R1 - Resolution bit reads one when the local end resolved to master, zero for slave.
// R2 - Local receiver bit mirrors the local receiver status input.
// R3 - Remote receiver bit mirrors the remote receiver status input.
// R4 - Partner full-duplex bit reads one when the partner advertised 1000BASE-T full duplex.
// R5 - Partner half-duplex bit reads one when the partner advertised 1000BASE-T half duplex.
// R6 - An 8-bit idle error count counts errors only while idles are received in send-normal mode.
// R7 - The count rises once per symbol period with an error, resets to zero and clears on read.
// R8 - The count saturates at 255 until a read clears it.
// R9 - The two-bit operation field selects address, data, data with post-increment, or write-only increment.
// R10 - A five-bit read/write field selects the extended device address, reset zero.
// R11 - In address mode the port stores and returns the extended register address.
// R12 - In a data mode the port reads and writes data at the selected device and stored address.
// R13 - After a data access the stored address advances per mode; mode 01 never advances.
// R14 - The host writes address mode and address first, then a data mode with the same device.
// R15 - The 1000BASE-X capability bits of the extended status read zero.
// R16 - The 1000BASE-T capability bits of the extended status read one.
// R17 - Each field obeys its access type: read/write, read-only, self-clearing, latch-high or latch-low.
package gls_pkg;
  //==========================================================================
  // register offsets (word index, byte address = 4 * index)
  localparam logic [3:0]  GLS_IDX_LINK_STATUS = 4'ha;
  localparam logic [3:0]  GLS_IDX_ACC_CTRL    = 4'hd;
  localparam logic [3:0]  GLS_IDX_ACC_PORT    = 4'he;
  localparam logic [3:0]  GLS_IDX_EXT_CAP     = 4'hf;
  localparam logic [3:0]  GLS_IDX_IRQ_STATUS  = 4'h4;
  localparam logic [3:0]  GLS_IDX_IRQ_ENABLE  = 4'h5;
  localparam logic [3:0]  GLS_IDX_IRQ_CLEAR   = 4'h6;
  //==========================================================================
  // field positions
  localparam int          GLS_BIT_RESOLVE     = 14;
  localparam int          GLS_BIT_LOC_RCVR    = 13;
  localparam int          GLS_BIT_REM_RCVR    = 12;
  localparam int          GLS_BIT_LP_FULL     = 11;
  localparam int          GLS_BIT_LP_HALF     = 10;
  localparam int          GLS_OP_MSB          = 15;
  localparam int          GLS_OP_LSB          = 14;
  localparam int          GLS_DEV_MSB         = 4;
  // interrupt bits: idle error event, local receiver lost, count saturated
  localparam int          GLS_IRQ_ERR         = 0;
  localparam int          GLS_IRQ_LOC_DOWN    = 1;
  localparam int          GLS_IRQ_SAT         = 2;
  localparam int          GLS_IRQ_W           = 3;
  //==========================================================================
  // reset and constant values
  localparam logic [7:0]  GLS_CNT_RST         = 8'h00;
  localparam logic [7:0]  GLS_CNT_MAX         = 8'hff;
  localparam logic [4:0]  GLS_DEV_RST         = 5'h00;
  localparam logic [15:0] GLS_PORT_RST        = 16'h0000;
  localparam logic [15:0] GLS_EXT_CAP_VAL     = 16'h3000;
  localparam int          GLS_EXT_AW          = 6;
  typedef enum logic [1:0] {
    GLS_OP_ADDR,
    GLS_OP_DATA,
    GLS_OP_DATA_INC_RW,
    GLS_OP_DATA_INC_WR
  } gls_op_type;
endpackage : gls_pkg

// *** src/gls_regs.sv ***
// gigabit status and extended access register bank with avalon slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module gls_regs
  import gls_pkg::*;
#(
  parameter int DEVS = 32
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ms_resolved_master,
  input  wire logic        loc_rcvr_ok,
  input  wire logic        rem_rcvr_ok,
  input  wire logic        lp_full_duplex,
  input  wire logic        lp_half_duplex,
  input  wire logic        symbol_tick,
  input  wire logic        rx_idle,
  input  wire logic        tx_send_normal,
  input  wire logic        rx_error,
  output logic             irq
);
  //==========================================================================
  // bus handshake: one wait cycle, answer on second edge
  logic              ack_reg;
  logic [3:0]        idx;
  logic              hit;
  assign idx = avs_address[5:2];
  assign hit = (avs_read | avs_write) & ~ack_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= hit;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~hit;
  logic              rd_take;
  logic              wr_take;
  assign rd_take = hit & avs_read;
  assign wr_take = hit & avs_write;
  //==========================================================================
  // status mirrors
  logic [15:0]       status_reg;
  logic [7:0]        cnt_reg;
  logic [7:0]        cnt_next;
  logic              err_ev;
  assign err_ev = symbol_tick & rx_idle & tx_send_normal & rx_error; // [R6] [R7]
  always_comb
  begin
    cnt_next = cnt_reg;
    if (rd_take && idx == GLS_IDX_LINK_STATUS)
      cnt_next = GLS_CNT_RST; // [R7] [R17]
    if (err_ev && cnt_next != GLS_CNT_MAX)
      cnt_next = cnt_next + 8'h01; // [R8]
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_reg <= GLS_CNT_RST;
    else
      cnt_reg <= cnt_next;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      status_reg <= 16'h0000;
    else
    begin
      status_reg                   <= 16'h0000;
      status_reg[GLS_BIT_RESOLVE]  <= ms_resolved_master; // [R1]
      status_reg[GLS_BIT_LOC_RCVR] <= loc_rcvr_ok; // [R2]
      status_reg[GLS_BIT_REM_RCVR] <= rem_rcvr_ok; // [R3]
      status_reg[GLS_BIT_LP_FULL]  <= lp_full_duplex; // [R4]
      status_reg[GLS_BIT_LP_HALF]  <= lp_half_duplex; // [R5]
    end
  //==========================================================================
  // extended access control and port
  gls_op_type        op_reg;
  logic [4:0]        dev_reg;
  logic [15:0]       addr_reg;
  logic [15:0]       ext_mem [DEVS][2**GLS_EXT_AW];
  logic              data_mode;
  logic              port_rd;
  logic              port_wr;
  assign data_mode = (op_reg != GLS_OP_ADDR); // [R12]
  assign port_rd = rd_take && idx == GLS_IDX_ACC_PORT;
  assign port_wr = wr_take && idx == GLS_IDX_ACC_PORT;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      op_reg  <= GLS_OP_ADDR; // [R9]
      dev_reg <= GLS_DEV_RST; // [R10]
    end
    else if (wr_take && idx == GLS_IDX_ACC_CTRL)
    begin
      op_reg  <= gls_op_type'(avs_writedata[GLS_OP_MSB:GLS_OP_LSB]); // [R9]
      dev_reg <= avs_writedata[GLS_DEV_MSB:0]; // [R10]
    end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      addr_reg <= GLS_PORT_RST;
    else if (port_wr && !data_mode)
      addr_reg <= avs_writedata[15:0]; // [R11]
    else if (data_mode && (port_wr || port_rd))
    begin
      case (op_reg)
        GLS_OP_DATA_INC_RW: addr_reg <= addr_reg + 16'h0001; // [R13]
        GLS_OP_DATA_INC_WR: if (port_wr) addr_reg <= addr_reg + 16'h0001; // [R13]
        default:            addr_reg <= addr_reg; // [R13]
      endcase
    end
  always_ff @(posedge clk)
    if (port_wr && data_mode)
      ext_mem[dev_reg][addr_reg[GLS_EXT_AW-1:0]] <= avs_writedata[15:0]; // [R12]
  //==========================================================================
  // interrupts
  logic [GLS_IRQ_W-1:0] irq_st_reg;
  logic [GLS_IRQ_W-1:0] irq_en_reg;
  logic [GLS_IRQ_W-1:0] irq_ev;
  logic [GLS_IRQ_W-1:0] irq_clr;
  assign irq_ev[GLS_IRQ_ERR]      = err_ev;
  assign irq_ev[GLS_IRQ_LOC_DOWN] = status_reg[GLS_BIT_LOC_RCVR] & ~loc_rcvr_ok;
  assign irq_ev[GLS_IRQ_SAT]      = err_ev & (cnt_reg == GLS_CNT_MAX);
  assign irq_clr = (wr_take && idx == GLS_IDX_IRQ_CLEAR) ? avs_writedata[GLS_IRQ_W-1:0] : '0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq_st_reg <= '0;
    else
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq_en_reg <= '0;
    else if (wr_take && idx == GLS_IDX_IRQ_ENABLE)
      irq_en_reg <= avs_writedata[GLS_IRQ_W-1:0];
  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(((irq_st_reg & ~irq_clr) | irq_ev) & irq_en_reg);
  //==========================================================================
  // read mux
  logic [15:0]       rd_val;
  always_comb
  begin
    rd_val = 16'h0000;
    case (idx)
      GLS_IDX_LINK_STATUS: rd_val = status_reg | {8'h00, cnt_reg};
      GLS_IDX_ACC_CTRL:    rd_val = {op_reg, 9'h000, dev_reg};
      GLS_IDX_ACC_PORT:    rd_val = data_mode ? ext_mem[dev_reg][addr_reg[GLS_EXT_AW-1:0]] : addr_reg; // [R11] [R12]
      GLS_IDX_EXT_CAP:     rd_val = GLS_EXT_CAP_VAL; // [R15] [R16]
      GLS_IDX_IRQ_STATUS:  rd_val = {13'h0000, irq_st_reg};
      GLS_IDX_IRQ_ENABLE:  rd_val = {13'h0000, irq_en_reg};
      default:             rd_val = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (rd_take)
      avs_readdata <= {16'h0000, rd_val};
  //==========================================================================
  // checks
  function automatic logic reg_sel(input logic [3:0] a, input logic [3:0] b);
    reg_sel = (a == b);
  endfunction : reg_sel

  //==========================================================================
  // bus handshake checks
  chk_bus_ans: assert property (@(posedge clk) disable iff (rst)
    avs_read && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
    else $error("no answer");
  chk_wr_ans: assert property (@(posedge clk) disable iff (rst)
    avs_write && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
    else $error("no write answer");
  chk_ack_follows: assert property (@(posedge clk) disable iff (rst)
    hit |=> ack_reg && !avs_waitrequest)
    else $error("taken request not answered");
  chk_wait_pulse: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (@(posedge clk) disable iff (rst)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_rd_upper: assert property (@(posedge clk) disable iff (rst)
    rd_take |=> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_rd_hold: assert property (@(posedge clk) disable iff (rst)
    !rd_take |=> $stable(avs_readdata))
    else $error("read data moved");
  chk_unmapped_rd: assert property (@(posedge clk) disable iff (rst)
    rd_take && reg_sel(idx, 4'h0) |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  //==========================================================================
  // idle error count checks
  chk_cnt_clear: assert property (@(posedge clk) disable iff (rst) // [R7]
    rd_take && idx == GLS_IDX_LINK_STATUS && !err_ev |=> cnt_reg == 8'h00)
    else $error("count not cleared on read");
  chk_cnt_sat: assert property (@(posedge clk) disable iff (rst) // [R8]
    cnt_reg == 8'hff && !rd_take |=> cnt_reg == 8'hff)
    else $error("count wrapped");
  chk_cnt_inc: assert property (@(posedge clk) disable iff (rst) // [R6]
    err_ev && !rd_take && cnt_reg != 8'hff |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("count missed error");
  chk_cnt_gate: assert property (@(posedge clk) disable iff (rst) // [R6]
    !(rx_idle && tx_send_normal) && !rd_take |=> $stable(cnt_reg))
    else $error("count moved outside idles");
  chk_cnt_rd_err: assert property (@(posedge clk) disable iff (rst) // [R7]
    rd_take && reg_sel(idx, GLS_IDX_LINK_STATUS) && err_ev |=> cnt_reg == 8'h01)
    else $error("error lost at clear");
  chk_cnt_no_tick: assert property (@(posedge clk) disable iff (rst) // [R7]
    !symbol_tick && !rd_take |=> $stable(cnt_reg))
    else $error("count moved without symbol");
  chk_cnt_no_err: assert property (@(posedge clk) disable iff (rst) // [R6]
    !rx_error && !rd_take |=> $stable(cnt_reg))
    else $error("count moved without error");
  chk_cnt_step: assert property (@(posedge clk) disable iff (rst) // [R7]
    !rd_take |=> cnt_reg == $past(cnt_reg) || cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("count jumped");
  chk_cnt_read_val: assert property (@(posedge clk) disable iff (rst) // [R7]
    rd_take && reg_sel(idx, GLS_IDX_LINK_STATUS) |=> avs_readdata[7:0] == $past(cnt_reg))
    else $error("count read wrong");

  //==========================================================================
  // link status checks
  chk_resolve_bit: assert property (@(posedge clk) disable iff (rst) // [R1]
    1'b1 |=> status_reg[14] == $past(ms_resolved_master))
    else $error("resolution bit wrong");
  chk_rcvr_bits: assert property (@(posedge clk) disable iff (rst) // [R2]
    1'b1 |=> status_reg[13:12] == $past({loc_rcvr_ok, rem_rcvr_ok}))
    else $error("receiver bits wrong");
  chk_lp_bits: assert property (@(posedge clk) disable iff (rst) // [R4]
    1'b1 |=> status_reg[11:10] == $past({lp_full_duplex, lp_half_duplex}))
    else $error("partner bits wrong");
  chk_rem_bit: assert property (@(posedge clk) disable iff (rst) // [R3]
    1'b1 |=> status_reg[GLS_BIT_REM_RCVR] == $past(rem_rcvr_ok))
    else $error("remote receiver bit wrong");
  chk_full_bit: assert property (@(posedge clk) disable iff (rst) // [R4]
    1'b1 |=> status_reg[GLS_BIT_LP_FULL] == $past(lp_full_duplex))
    else $error("partner full bit wrong");
  chk_half_bit: assert property (@(posedge clk) disable iff (rst) // [R5]
    1'b1 |=> status_reg[GLS_BIT_LP_HALF] == $past(lp_half_duplex))
    else $error("partner half bit wrong");
  chk_status_rd: assert property (@(posedge clk) disable iff (rst) // [R1]
    rd_take && reg_sel(idx, GLS_IDX_LINK_STATUS) |=> avs_readdata[14:10] == $past(status_reg[14:10]))
    else $error("status read wrong");
  chk_rsvd_bits: assert property (@(posedge clk) disable iff (rst) // [R17]
    rd_take && reg_sel(idx, GLS_IDX_LINK_STATUS) |=> avs_readdata[15] == 1'b0 && avs_readdata[9:8] == 2'b00)
    else $error("reserved status bits set");

  //==========================================================================
  // extended access and extended status checks
  chk_no_inc: assert property (@(posedge clk) disable iff (rst) // [R13]
    port_rd && (op_reg == GLS_OP_DATA || op_reg == GLS_OP_DATA_INC_WR) |=> $stable(addr_reg))
    else $error("address advanced");
  chk_inc_rw: assert property (@(posedge clk) disable iff (rst) // [R13]
    port_rd && op_reg == GLS_OP_DATA_INC_RW |=> addr_reg == $past(addr_reg) + 16'h0001)
    else $error("address not advanced");
  chk_ext_cap: assert property (@(posedge clk) disable iff (rst) // [R15]
    rd_take && idx == GLS_IDX_EXT_CAP |=> avs_readdata == 32'h0000_3000)
    else $error("capability wrong");
  chk_ctrl_wr: assert property (@(posedge clk) disable iff (rst) // [R9]
    wr_take && reg_sel(idx, GLS_IDX_ACC_CTRL) |=> op_reg == $past(avs_writedata[15:14]))
    else $error("operation field not stored");
  chk_dev_wr: assert property (@(posedge clk) disable iff (rst) // [R10]
    wr_take && reg_sel(idx, GLS_IDX_ACC_CTRL) |=> dev_reg == $past(avs_writedata[4:0]))
    else $error("device field not stored");
  chk_ctrl_hold: assert property (@(posedge clk) disable iff (rst) // [R10]
    !(wr_take && reg_sel(idx, GLS_IDX_ACC_CTRL)) |=> $stable(op_reg) && $stable(dev_reg))
    else $error("control changed unasked");
  chk_ctrl_rd: assert property (@(posedge clk) disable iff (rst) // [R10]
    rd_take && reg_sel(idx, GLS_IDX_ACC_CTRL) |=> avs_readdata[4:0] == $past(dev_reg))
    else $error("control read wrong");
  chk_addr_wr: assert property (@(posedge clk) disable iff (rst) // [R11]
    port_wr && !data_mode |=> addr_reg == $past(avs_writedata[15:0]))
    else $error("address not stored");
  chk_addr_rd: assert property (@(posedge clk) disable iff (rst) // [R11]
    port_rd && !data_mode |=> avs_readdata[15:0] == $past(addr_reg))
    else $error("address read wrong");
  chk_addr_rd_stay: assert property (@(posedge clk) disable iff (rst) // [R11]
    port_rd && !data_mode |=> $stable(addr_reg))
    else $error("address moved on read");
  chk_wr_inc: assert property (@(posedge clk) disable iff (rst) // [R13]
    port_wr && (op_reg == GLS_OP_DATA_INC_RW || op_reg == GLS_OP_DATA_INC_WR) |=>
      addr_reg == $past(addr_reg) + 16'h0001)
    else $error("address not advanced on write");
  chk_wr_no_inc: assert property (@(posedge clk) disable iff (rst) // [R13]
    port_wr && op_reg == GLS_OP_DATA |=> $stable(addr_reg))
    else $error("address advanced on write");
  chk_addr_idle: assert property (@(posedge clk) disable iff (rst) // [R12]
    !port_wr && !port_rd |=> $stable(addr_reg))
    else $error("address moved unasked");
  chk_cap_t: assert property (@(posedge clk) disable iff (rst) // [R16]
    rd_take && reg_sel(idx, GLS_IDX_EXT_CAP) |=> avs_readdata[13:12] == 2'b11)
    else $error("twisted pair capability wrong");
  chk_cap_x: assert property (@(posedge clk) disable iff (rst) // [R15]
    rd_take && reg_sel(idx, GLS_IDX_EXT_CAP) |=> avs_readdata[15:14] == 2'b00)
    else $error("fibre capability wrong");

  //==========================================================================
  // interrupt checks
  chk_irq_level: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> irq == |(irq_st_reg & $past(irq_en_reg)))
    else $error("interrupt level wrong");
  chk_irq_set: assert property (@(posedge clk) disable iff (rst)
    irq_ev[GLS_IRQ_ERR] |=> irq_st_reg[GLS_IRQ_ERR])
    else $error("error event not latched");
  chk_irq_sticky: assert property (@(posedge clk) disable iff (rst)
    irq_st_reg[GLS_IRQ_ERR] && !irq_clr[GLS_IRQ_ERR] |=> irq_st_reg[GLS_IRQ_ERR])
    else $error("status bit lost");
  chk_irq_clr: assert property (@(posedge clk) disable iff (rst)
    irq_clr[GLS_IRQ_ERR] && !irq_ev[GLS_IRQ_ERR] |=> !irq_st_reg[GLS_IRQ_ERR])
    else $error("status bit not cleared");
  chk_loc_down: assert property (@(posedge clk) disable iff (rst) // [R2]
    status_reg[GLS_BIT_LOC_RCVR] && !loc_rcvr_ok |=> irq_st_reg[GLS_IRQ_LOC_DOWN])
    else $error("receiver loss not latched");
  chk_sat_irq: assert property (@(posedge clk) disable iff (rst) // [R8]
    err_ev && cnt_reg == GLS_CNT_MAX |=> irq_st_reg[GLS_IRQ_SAT])
    else $error("saturation not latched");
  chk_en_wr: assert property (@(posedge clk) disable iff (rst)
    wr_take && reg_sel(idx, GLS_IDX_IRQ_ENABLE) |=> irq_en_reg == $past(avs_writedata[GLS_IRQ_W-1:0]))
    else $error("enable not stored");
  chk_en_hold: assert property (@(posedge clk) disable iff (rst)
    !(wr_take && reg_sel(idx, GLS_IDX_IRQ_ENABLE)) |=> $stable(irq_en_reg))
    else $error("enable changed unasked");
  chk_st_rd: assert property (@(posedge clk) disable iff (rst)
    rd_take && reg_sel(idx, GLS_IDX_IRQ_STATUS) |=> avs_readdata[15:0] == {13'h0000, $past(irq_st_reg)})
    else $error("status read wrong");
  chk_en_rd: assert property (@(posedge clk) disable iff (rst)
    rd_take && reg_sel(idx, GLS_IDX_IRQ_ENABLE) |=> avs_readdata[15:0] == {13'h0000, $past(irq_en_reg)})
    else $error("enable read wrong");
  chk_clr_rd: assert property (@(posedge clk) disable iff (rst)
    rd_take && reg_sel(idx, GLS_IDX_IRQ_CLEAR) |=> avs_readdata == 32'h0000_0000)
    else $error("clear register readable");

  //==========================================================================
  // scenario covers
  cov_port_wr: cover property (@(posedge clk) port_wr && data_mode);
  cov_sat: cover property (@(posedge clk) cnt_reg == 8'hff);
  cov_irq: cover property (@(posedge clk) irq);
  cov_inc_wr: cover property (@(posedge clk) port_wr && op_reg == GLS_OP_DATA_INC_WR);
  cov_addr_rd: cover property (@(posedge clk) port_rd && !data_mode);
endmodule : gls_regs

// *** sim/gls_line_model.sv ***
// line-side model: status levels and symbol stream feeding the register bank
`timescale 1ns/1ps
module gls_line_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [8:0] ctl,
  output logic [8:0]      line
);
  //==========================================================================
  // registered levels: resolve, loc, rem, full, half, tick, idle, normal, error
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      line <= 9'h000;
    else
      line <= ctl;
  end
endmodule : gls_line_model

// *** sim/phy_gigabit_status_mmd_access_regs_tb.sv ***
// self-checking bench for the gigabit status and extended access bank
`timescale 1ns/1ps
module phy_gigabit_status_mmd_access_regs_tb;
  import gls_pkg::*;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [8:0]  ctl, line;
  logic [15:0] exp_q[$];
  int          err_total, checks, cyc, r;
  int          seed = 32'hcb12eec9;
  gls_regs i_gls_regs (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ms_resolved_master(line[8]), .loc_rcvr_ok(line[7]),
    .rem_rcvr_ok(line[6]), .lp_full_duplex(line[5]), .lp_half_duplex(line[4]), .symbol_tick(line[3]),
    .rx_idle(line[2]), .tx_send_normal(line[1]), .rx_error(line[0]), .irq(irq));
  gls_line_model i_gls_line_model (.clk(clk), .rst(rst), .ctl(ctl), .line(line));
  //==========================================================================
  // clock, compare, monitor, timeout
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, {16'h0000, exp_q.pop_front()});
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  //==========================================================================
  // avalon master: hold until waitrequest sampled low, then release
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    if (!wr)
      exp_q.push_back(d);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic hold(input logic [8:0] v, input int n);
    ctl <= v;
    repeat (n) @(posedge clk);
  endtask : hold
  //==========================================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    ctl = 9'h000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, 6'h28, 16'h0000);
    bus(0, 6'h34, 16'h0000);
    bus(0, 6'h38, 16'h0000);
    bus(0, 6'h3c, 16'h3000);
    bus(1, 6'h3c, 16'hffff);
    bus(0, 6'h3c, 16'h3000);
    bus(0, 6'h00, 16'h0000);
    repeat (4)
    begin
      r = $random(seed);
      hold({r[4:0], 4'h0}, 3);
      bus(0, 6'h28, {r[4:0], 10'h000});
    end
    hold(9'h00f, 5);
    hold(9'h00b, 2);
    hold(9'h00d, 2);
    hold(9'h007, 2);
    hold(9'h000, 3);
    bus(0, 6'h28, 16'h0005);
    bus(0, 6'h28, 16'h0000);
    hold(9'h00f, 300);
    hold(9'h000, 3);
    bus(0, 6'h28, 16'h00ff);
    bus(1, 6'h34, 16'h0003);
    bus(1, 6'h38, 16'h0005);
    bus(0, 6'h38, 16'h0005);
    bus(1, 6'h34, 16'h8003);
    bus(0, 6'h34, 16'h8003);
    bus(1, 6'h38, 16'haaaa);
    bus(1, 6'h38, 16'h5555);
    bus(1, 6'h34, 16'h0003);
    bus(0, 6'h38, 16'h0007);
    bus(1, 6'h38, 16'h0005);
    bus(1, 6'h34, 16'h4003);
    bus(0, 6'h38, 16'haaaa);
    bus(0, 6'h38, 16'haaaa);
    bus(1, 6'h34, 16'h8003);
    bus(0, 6'h38, 16'haaaa);
    bus(0, 6'h38, 16'h5555);
    bus(1, 6'h34, 16'h0003);
    bus(0, 6'h38, 16'h0007);
    bus(1, 6'h38, 16'h0006);
    bus(1, 6'h34, 16'hc003);
    bus(0, 6'h38, 16'h5555);
    bus(0, 6'h38, 16'h5555);
    bus(1, 6'h38, 16'h1234);
    bus(1, 6'h34, 16'h0003);
    bus(0, 6'h38, 16'h0007);
    bus(1, 6'h18, 16'h0007);
    bus(1, 6'h14, 16'h0001);
    hold(9'h00f, 1);
    hold(9'h000, 4);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1, 6'h18, 16'h0001);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1, 6'h14, 16'h0000);
    hold(9'h00f, 1);
    hold(9'h000, 4);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(0, 6'h10, 16'h0001);
    tally_and_finish();
  end
endmodule : phy_gigabit_status_mmd_access_regs_tb
